// >>> design/gmtp_pkg.sv
// Purpose: Shared constants and types for the global mode and test pattern register block.
// Assumes: Eight-bit registers behind a three-wire serial port, 14-bit converter samples.
// Notes: Offsets are the serial-port register addresses.
package gmtp_pkg;
  // Register addresses.
  localparam logic [12:0] GMTP_ADDR_MODES = 13'h0008;
  localparam logic [12:0] GMTP_ADDR_CLOCK = 13'h0009;
  localparam logic [12:0] GMTP_ADDR_PLL = 13'h000A;
  localparam logic [12:0] GMTP_ADDR_TEST = 13'h000D;
  // Values after reset.
  localparam logic [7:0] GMTP_MODES_RST = 8'h01;
  localparam logic [7:0] GMTP_CLOCK_RST = 8'h01;
  localparam logic [7:0] GMTP_TEST_RST = 8'h00;
  // Field positions.
  localparam int GMTP_IMP_BIT = 6;
  localparam int GMTP_DCS_BIT = 0;
  localparam int GMTP_LOCK_BIT = 7;
  localparam int GMTP_UMODE_BIT = 7;
  localparam int GMTP_PNL_BIT = 5;
  localparam int GMTP_PNS_BIT = 4;
  // Power-down field codes.
  localparam logic [2:0] GMTP_PD_RUN = 3'h0;
  localparam logic [2:0] GMTP_PD_FULL = 3'h1;
  localparam logic [2:0] GMTP_PD_STBY = 3'h2;
  localparam logic [2:0] GMTP_PD_LVDS = 3'h3;
  localparam logic [2:0] GMTP_PD_CW = 3'h4;
  // Output test field codes.
  typedef enum logic [3:0] {
    GMTP_T_OFF = 4'h0, GMTP_T_MID = 4'h1, GMTP_T_PFS = 4'h2, GMTP_T_NFS = 4'h3,
    GMTP_T_CHK = 4'h4, GMTP_T_PNL = 4'h5, GMTP_T_PNS = 4'h6, GMTP_T_TOG = 4'h7,
    GMTP_T_USER = 4'h8
  } gmtp_test_t;
  // Fixed pattern words, offset binary.
  localparam logic [13:0] GMTP_MID = 14'h2000;
  localparam logic [13:0] GMTP_PFS = 14'h3FFF;
  localparam logic [13:0] GMTP_NFS = 14'h0000;
  localparam logic [13:0] GMTP_CHK_A = 14'h2AAA;
  localparam logic [13:0] GMTP_CHK_B = 14'h1555;
  // Generator seeds.
  localparam logic [8:0] GMTP_PNS_SEED = 9'h1FF;
  localparam logic [22:0] GMTP_PNL_SEED = 23'h7FFFFF;
  // Serial frame counts and user pattern count.
  localparam logic [4:0] GMTP_INSTR_BITS = 5'h10;
  localparam logic [2:0] GMTP_LAST_DBIT = 3'h7;
  localparam logic [2:0] GMTP_USER_CNT = 3'h4;
  // Serial port states.
  typedef enum logic [1:0] {
    GMTP_S_IDLE = 2'b00,
    GMTP_S_INSTR = 2'b01,
    GMTP_S_DATA = 2'b10
  } gmtp_spi_t;
endpackage

// >>> design/gmtp_pat_if.sv
// Purpose: Carries one channel's test control, sample and output word.
// Assumes: One instance per channel.
// Notes: The register side drives test, adc and user; the generator drives dout.
`timescale 1ns/100ps
interface gmtp_pat_if #(parameter int DW = 14);
  // Copy of the channel's test register.
  logic [7:0] test;
  // Converter sample for this channel.
  logic [DW-1:0] adc;
  // Four user patterns, pattern 1 in the low word.
  logic [4*DW-1:0] user;
  // Channel output word.
  logic [DW-1:0] dout;
  modport src (output test, output adc, output user, input dout);
  modport gen (input test, input adc, input user, output dout);
endinterface

// >>> design/gmtp_pat_gen.sv
// Purpose: Per-channel output pattern generator that replaces converter data.
// Assumes: Sample rate equals mclk; ce freezes the generator.
// Notes: Reserved test codes pass converter data through.
`timescale 1ns/100ps
module gmtp_pat_gen
  import gmtp_pkg::*;
#(
  parameter int DW = 14
)
(
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Channel carrier.
  gmtp_pat_if.gen pif
);
  // Whole generator state.
  typedef struct packed {
    logic [8:0] pns;
    logic [22:0] pnl;
    logic tog;
    logic [2:0] uidx;
    logic [3:0] last;
    logic [DW-1:0] dout;
  } gmtp_gen_st_t;

  gmtp_gen_st_t s_r;
  gmtp_gen_st_t s_nxt;
  logic [3:0] code;
  logic [DW-1:0] uword;

  // Next-state logic for generators and output word.
  always_comb
  begin
    s_nxt = s_r;
    code = pif.test[3:0];
    uword = '0;
    if (pif.test[GMTP_PNS_BIT])
      s_nxt.pns = GMTP_PNS_SEED;
    else
      s_nxt.pns = {s_r.pns[7:0], s_r.pns[8] ^ s_r.pns[4]};
    if (pif.test[GMTP_PNL_BIT])
      s_nxt.pnl = GMTP_PNL_SEED;
    else
      s_nxt.pnl = {s_r.pnl[21:0], s_r.pnl[22] ^ s_r.pnl[17]};
    s_nxt.tog = ~s_r.tog;
    s_nxt.last = code;
    // User sequence restarts on entry and repeats in user mode 0.
    if (s_r.last != GMTP_T_USER || (s_r.uidx == GMTP_USER_CNT && !pif.test[GMTP_UMODE_BIT]))
    begin
      uword = pif.user[0 +: DW];
      s_nxt.uidx = 3'h1;
    end
    else if (s_r.uidx == GMTP_USER_CNT)
    begin
      uword = '0;
    end
    else
    begin
      uword = pif.user[s_r.uidx[1:0]*DW +: DW];
      s_nxt.uidx = s_r.uidx + 3'h1;
    end
    case (code)
      GMTP_T_MID: s_nxt.dout = GMTP_MID[DW-1:0];
      GMTP_T_PFS: s_nxt.dout = GMTP_PFS[DW-1:0];
      GMTP_T_NFS: s_nxt.dout = GMTP_NFS[DW-1:0];
      GMTP_T_CHK: s_nxt.dout = s_r.tog ? GMTP_CHK_B[DW-1:0] : GMTP_CHK_A[DW-1:0];
      GMTP_T_PNL: s_nxt.dout = s_r.pnl[DW-1:0];
      GMTP_T_PNS: s_nxt.dout = {s_r.pns, s_r.pns[DW-10:0]};
      GMTP_T_TOG: s_nxt.dout = {DW{s_r.tog}};
      GMTP_T_USER: s_nxt.dout = uword;
      // Off and reserved codes keep converter data.
      default: s_nxt.dout = pif.adc;
    endcase
  end

  // State register; the enable freezes everything.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.pns <= GMTP_PNS_SEED;
      s_r.pnl <= GMTP_PNL_SEED;
    end
    else if (ce)
      s_r <= s_nxt;
  end

  assign pif.dout = s_r.dout;
endmodule

// >>> design/gmtp_regs.sv
// Purpose: Serial-port register bank for global modes, clock control, lock flag and channel test control.
// Assumes: Serial port pins are synchronous to mclk and sclk is well below mclk/4.
// Notes: Instruction is 16 bits, read flag first, 13-bit address last, then 8 data bits MSB first.
//
// Overview of operation
// - Decode three-bit power-down field into states.
// - Power-down field resets to full power-down.
// - Code 011 restores serial-output register defaults.
// - Bit 6 picks 3 kOhm preamplifier impedance.
// - Clock bit 0 enables stabilizer, resets on.
// - Lock flag bit 7 read-only, writes ignored.
// - Test codes 1 to 8 replace selected channel data.
// - Test field selects fixed, pseudorandom, user patterns.
// - User mode 0 repeats four user patterns.
// - User mode 1 sends four patterns, then zeros.
// - Test bit 5 holds long generator reset.
// - Test bit 4 holds short generator reset.
// - Channel writes reach only selected channels.
`timescale 1ns/100ps
module gmtp_regs
  import gmtp_pkg::*;
#(
  parameter int NCH = 8,
  parameter int DW = 14
)
(
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Serial port; the data pin is split into three signals.
  input wire logic spi_csb_n,
  input wire logic spi_sclk,
  input wire logic spi_sdio_in,
  output logic spi_sdio_out,
  output logic spi_sdio_oe,
  // Channel select bits from the index registers.
  input wire logic [NCH-1:0] ch_select,
  // User pattern words, pattern 1 lowest.
  input wire logic [4*DW-1:0] user_pattern,
  // Analog status.
  input wire logic pll_locked,
  // Power state and analog controls.
  output logic pwr_run,
  output logic pwr_full_down,
  output logic pwr_standby,
  output logic pwr_cw,
  output logic preamp_3k,
  output logic dcs_on,
  output logic lvds_defaults,
  // Sample path.
  input wire logic [NCH*DW-1:0] adc_data,
  output logic [NCH*DW-1:0] out_data
);
  // Whole register-bank state.
  typedef struct packed {
    gmtp_spi_t st;
    logic sclk_q;
    logic [4:0] cnt;
    logic [15:0] instr;
    logic [7:0] dsh;
    logic [12:0] addr;
    logic rd;
    logic sdo;
    logic oe;
    logic lvds;
    logic [7:0] modes;
    logic [7:0] gclk;
    logic [NCH-1:0][7:0] test;
  } gmtp_reg_st_t;

  gmtp_reg_st_t s_r;
  gmtp_reg_st_t s_nxt;
  // Edges of the sampled serial clock.
  logic rise;
  logic fall;
  // Byte completed on this edge.
  logic [7:0] wbyte;
  logic [15:0] ibits;
  logic [4:0] icnt;
  logic [2:0] pd;

  // Read value for an address; the test register shows the lowest selected channel.
  function automatic logic [7:0] rd_val(input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      GMTP_ADDR_MODES: v = s_r.modes;
      GMTP_ADDR_CLOCK: v = s_r.gclk;
      // Lock flag comes straight from the pin.
      GMTP_ADDR_PLL: v = {pll_locked, 7'h00};
      GMTP_ADDR_TEST:
      begin
        v = s_r.test[0];
        for (int i = NCH - 1; i >= 0; i--)
        begin
          if (ch_select[i])
            v = s_r.test[i];
        end
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Serial frame handling and register writes.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sclk_q = spi_sclk;
    s_nxt.lvds = 1'b0;
    rise = spi_sclk & ~s_r.sclk_q;
    fall = ~spi_sclk & s_r.sclk_q;
    wbyte = {s_r.dsh[6:0], spi_sdio_in};
    ibits = {s_r.instr[14:0], spi_sdio_in};
    icnt = (s_r.st == GMTP_S_IDLE) ? 5'h01 : s_r.cnt + 5'h01;
    pd = wbyte[2:0];
    if (spi_csb_n)
    begin
      // Deselect ends any frame and releases the pin.
      s_nxt.st = GMTP_S_IDLE;
      s_nxt.cnt = '0;
      s_nxt.oe = 1'b0;
    end
    else
    begin
      case (s_r.st)
        GMTP_S_IDLE, GMTP_S_INSTR:
        begin
          if (rise)
          begin
            s_nxt.instr = ibits;
            s_nxt.cnt = icnt;
            s_nxt.st = GMTP_S_INSTR;
            if (icnt == GMTP_INSTR_BITS)
            begin
              // Instruction done; preload the read byte.
              s_nxt.st = GMTP_S_DATA;
              s_nxt.cnt = '0;
              s_nxt.rd = ibits[15];
              s_nxt.addr = ibits[12:0];
              s_nxt.dsh = rd_val(ibits[12:0]);
              s_nxt.oe = ibits[15];
            end
          end
        end
        GMTP_S_DATA:
        begin
          if (fall && s_r.rd)
          begin
            // Read bits leave on the falling edge.
            s_nxt.sdo = s_r.dsh[7];
            s_nxt.dsh = {s_r.dsh[6:0], 1'b0};
          end
          else if (rise)
          begin
            s_nxt.cnt = s_r.cnt + 5'h01;
            if (!s_r.rd)
              s_nxt.dsh = wbyte;
            if (s_r.cnt[2:0] == GMTP_LAST_DBIT)
            begin
              // Byte done; streaming steps down one address.
              s_nxt.cnt = '0;
              s_nxt.addr = s_r.addr - 13'h0001;
              if (s_r.rd)
                s_nxt.dsh = rd_val(s_r.addr - 13'h0001);
              else
              begin
                case (s_r.addr)
                  GMTP_ADDR_MODES:
                  begin
                    s_nxt.modes[GMTP_IMP_BIT] = wbyte[GMTP_IMP_BIT];
                    if (pd == GMTP_PD_LVDS)
                      s_nxt.lvds = 1'b1;
                    else if (pd <= GMTP_PD_CW)
                      s_nxt.modes[2:0] = pd;
                  end
                  GMTP_ADDR_CLOCK: s_nxt.gclk[GMTP_DCS_BIT] = wbyte[GMTP_DCS_BIT];
                  GMTP_ADDR_TEST:
                  begin
                    // Only selected channels take the write.
                    for (int i = 0; i < NCH; i++)
                    begin
                      if (ch_select[i])
                        s_nxt.test[i] = {wbyte[7], 1'b0, wbyte[5:0]};
                    end
                  end
                  // Lock flag and unmapped addresses ignore writes.
                  default: s_nxt.lvds = 1'b0;
                endcase
              end
            end
          end
        end
        default: s_nxt.st = GMTP_S_IDLE;
      endcase
    end
  end

  // State register; reset takes constants only.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.modes <= GMTP_MODES_RST;
      s_r.gclk <= GMTP_CLOCK_RST;
      s_r.test <= {NCH{GMTP_TEST_RST}};
    end
    else if (ce)
      s_r <= s_nxt;
  end

  // Power state decode from the stored field.
  assign pwr_run = (s_r.modes[2:0] == GMTP_PD_RUN);
  assign pwr_full_down = (s_r.modes[2:0] == GMTP_PD_FULL);
  assign pwr_standby = (s_r.modes[2:0] == GMTP_PD_STBY);
  assign pwr_cw = (s_r.modes[2:0] == GMTP_PD_CW);
  assign preamp_3k = s_r.modes[GMTP_IMP_BIT];
  assign dcs_on = s_r.gclk[GMTP_DCS_BIT];
  assign lvds_defaults = s_r.lvds;
  // Serial data pin.
  assign spi_sdio_out = s_r.sdo;
  assign spi_sdio_oe = s_r.oe;

  // One carrier and generator per channel.
  gmtp_pat_if #(.DW(DW)) pif [NCH] ();
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    assign pif[g].test = s_r.test[g];
    assign pif[g].adc = adc_data[g*DW +: DW];
    assign pif[g].user = user_pattern;
    assign out_data[g*DW +: DW] = pif[g].dout;
    gmtp_pat_gen #(.DW(DW)) u_gen (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .pif(pif[g])
    );
  end
endmodule

// >>> verification/gmtp_spi_host.sv
// Purpose: Serial-port host model that writes and reads one register per frame.
// Assumes: Three mclk cycles per sclk phase.
// Notes: In a read data phase the pin is released and shows a changing level.
`timescale 1ns/100ps
module gmtp_spi_host
(
  // Clock.
  input wire logic mclk,
  // Serial pins.
  output logic csb_n,
  output logic sclk,
  output logic sdo,
  input wire logic sdio
);
  // Half sclk period in mclk cycles; the device needs two at least.
  localparam int HALF = 3;
  initial
  begin
    csb_n = 1'b1;
    sclk = 1'b0;
    sdo = 1'b0;
  end
  // One frame: read flag, two ignored bits, address, one data byte.
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd, output logic [7:0] rv);
    logic [23:0] f;
    f = {rd, 2'b00, addr, wd};
    rv = 8'h00;
    @(posedge mclk);
    csb_n <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      // Released pin flips each bit, so a stale copy is never read as data.
      sdo <= (rd && i < 8) ? ~sdo : f[i];
      repeat (HALF) @(posedge mclk);
      if (i < 8)
        rv[i] = sdio;
      sclk <= 1'b1;
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge mclk);
    csb_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
endmodule

// >>> verification/gmtp_regs_sva.sv
// Purpose: Port checks for the register block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound into every gmtp_regs instance.
`timescale 1ns/100ps
module gmtp_regs_chk
#(
  parameter int NCH = 8,
  parameter int DW = 14
)
(
  // Clock and control.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Serial port.
  input wire logic spi_csb_n,
  input wire logic spi_sclk,
  input wire logic spi_sdio_in,
  input wire logic spi_sdio_out,
  input wire logic spi_sdio_oe,
  // Status and controls.
  input wire logic [NCH-1:0] ch_select,
  input wire logic [4*DW-1:0] user_pattern,
  input wire logic pll_locked,
  input wire logic pwr_run,
  input wire logic pwr_full_down,
  input wire logic pwr_standby,
  input wire logic pwr_cw,
  input wire logic preamp_3k,
  input wire logic dcs_on,
  input wire logic lvds_defaults,
  // Samples.
  input wire logic [NCH*DW-1:0] adc_data,
  input wire logic [NCH*DW-1:0] out_data
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Power state, run first.
  logic [3:0] pwr;
  assign pwr = {pwr_run, pwr_full_down, pwr_standby, pwr_cw};
  // High until the first frame, so no test code can be live yet.
  logic quiet_r;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      quiet_r <= 1'b1;
    else if (!spi_csb_n)
      quiet_r <= 1'b0;
  end
  pwr_onehot_a: assert property ($onehot(pwr))
    else $error("power state not one-hot");
  reset_state_a: assert property ($rose(rst_n) |-> pwr_full_down && dcs_on && !preamp_3k)
    else $error("wrong state after reset");
  lvds_pulse_a: assert property (lvds_defaults |-> $stable(pwr) ##1 !lvds_defaults)
    else $error("defaults pulse wrong");
  pwr_write_a: assert property ($changed(pwr) |-> !$past(spi_csb_n))
    else $error("power changed outside a frame");
  preamp_write_a: assert property ($changed(preamp_3k) |-> !$past(spi_csb_n))
    else $error("impedance changed outside a frame");
  dcs_write_a: assert property ($changed(dcs_on) |-> !$past(spi_csb_n))
    else $error("stabilizer changed outside a frame");
  idle_data_a: assert property ($past(quiet_r) && $past(rst_n) && $past(ce) |-> out_data == $past(adc_data))
    else $error("converter data not passed");
  // A low enable freezes outputs.
  ce_freeze_a: assert property (!ce |=> $stable(out_data) && $stable(pwr))
    else $error("state moved while frozen");
  // Pin released between frames.
  oe_release_a: assert property (spi_csb_n [*2] |=> !spi_sdio_oe)
    else $error("data pin driven between frames");
  lvds_c: cover property (lvds_defaults);
  cw_c: cover property (pwr_cw);
  read_c: cover property (spi_sdio_oe && spi_sdio_out);
endmodule

bind gmtp_regs gmtp_regs_chk #(.NCH(NCH), .DW(DW)) chk
(
  .mclk(mclk), .rst_n(rst_n), .ce(ce), .spi_csb_n(spi_csb_n), .spi_sclk(spi_sclk),
  .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe),
  .ch_select(ch_select), .user_pattern(user_pattern), .pll_locked(pll_locked),
  .pwr_run(pwr_run), .pwr_full_down(pwr_full_down), .pwr_standby(pwr_standby), .pwr_cw(pwr_cw),
  .preamp_3k(preamp_3k), .dcs_on(dcs_on), .lvds_defaults(lvds_defaults),
  .adc_data(adc_data), .out_data(out_data)
);

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the register block and its test patterns.
// Assumes: Host model reaches registers; bench drives samples and status.
// Notes: Channel n carries 0x1000 plus n as converter data.
`timescale 1ns/100ps
module testbench;
  import gmtp_pkg::*;
  localparam int NCH = 8;
  localparam int DW = 14;
  // Roughly three and a half times the expected run length.
  localparam int LIMIT = 20000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic csb_n, sclk, host_sdo, sdio_out, sdio_oe, sdio;
  logic [NCH-1:0] ch_select = 8'hFF;
  logic [4*DW-1:0] user_pattern = {14'h0444, 14'h0333, 14'h0222, 14'h0111};
  logic pll_locked = 1'b1;
  logic preamp_3k, dcs_on, lvds;
  // Count of defaults pulses seen on the serial-output reset line.
  int lvds_pulses = 0;
  logic [3:0] pwr;
  logic [NCH*DW-1:0] adc_data, out_data;
  logic [7:0] rv;
  logic [13:0] prev;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Row: address, write value, readback, {preamp, dcs, run, full, standby, cw}.
  typedef struct packed { logic [12:0] a; logic [7:0] wd; logic [7:0] rd; logic [7:0] st; } gmtp_row_t;
  gmtp_row_t rows [10] = '{
    '{13'h0008, 8'h00, 8'h00, 8'h18}, '{13'h0008, 8'h02, 8'h02, 8'h12}, '{13'h0008, 8'h04, 8'h04, 8'h11},
    '{13'h0008, 8'h41, 8'h41, 8'h34}, '{13'h0008, 8'h03, 8'h01, 8'h14}, '{13'h0008, 8'h07, 8'h01, 8'h14},
    '{13'h0009, 8'h00, 8'h00, 8'h04}, '{13'h0009, 8'hFF, 8'h01, 8'h14}, '{13'h000A, 8'h00, 8'h80, 8'h14},
    '{13'h000C, 8'h55, 8'h00, 8'h14}};
  // Pin level: device while it drives, host otherwise.
  assign sdio = sdio_oe ? sdio_out : host_sdo;
  always #5 mclk = ~mclk;
  gmtp_spi_host host (.mclk(mclk), .csb_n(csb_n), .sclk(sclk), .sdo(host_sdo), .sdio(sdio));
  gmtp_regs #(.NCH(NCH), .DW(DW)) uut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .spi_csb_n(csb_n),
    .spi_sclk(sclk), .spi_sdio_in(sdio), .spi_sdio_out(sdio_out), .spi_sdio_oe(sdio_oe),
    .ch_select(ch_select), .user_pattern(user_pattern), .pll_locked(pll_locked), .pwr_run(pwr[3]),
    .pwr_full_down(pwr[2]), .pwr_standby(pwr[1]), .pwr_cw(pwr[0]), .preamp_3k(preamp_3k),
    .dcs_on(dcs_on), .lvds_defaults(lvds), .adc_data(adc_data), .out_data(out_data));
  function automatic logic [13:0] ch(input int i);
    return out_data[i*DW +: DW];
  endfunction
  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_sample(input string what, input logic [13:0] exp, input logic [13:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, rv);
  endtask
  task automatic rd(input logic [12:0] a);
    host.xfer(1'b1, a, 8'h00, rv);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // A hang counts as a failure and still reaches the report.
  always @(posedge mclk)
  begin
    cycles++;
    if (lvds === 1'b1)
      lvds_pulses++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      wrap_up();
    end
  end
  initial
  begin
    for (int i = 0; i < NCH; i++)
      adc_data[i*DW +: DW] = 14'h1000 + 14'(i);
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].wd);
      rd(rows[i].a);
      chk_reg("readback", rows[i].rd, rv);
      chk_reg("status", rows[i].st, {2'b00, preamp_3k, dcs_on, pwr});
    end
    // Only the single code 011 row should have raised the defaults pulse.
    chk_reg("lvds pulses", 8'h01, 8'(lvds_pulses));
    // The lock flag must follow the pin when the loop drops out of lock.
    pll_locked <= 1'b0;
    rd(GMTP_ADDR_PLL);
    chk_reg("lock lost", 8'h00, rv);
    pll_locked <= 1'b1;
    $display("test rows done");
    // Only channels 0 and 2 take the test writes below.
    ch_select <= 8'h05;
    for (int c = 1; c <= 3; c++)
    begin
      wr(GMTP_ADDR_TEST, 8'(c));
      chk_sample("fixed", c == 1 ? GMTP_MID : (c == 2 ? GMTP_PFS : GMTP_NFS), ch(2));
      chk_sample("unselected", 14'h1001, ch(1));
    end
    // Checkerboard then toggle: each word is the inverse of the one before.
    for (int c = 4; c <= 7; c += 3)
    begin
      wr(GMTP_ADDR_TEST, 8'(c));
      prev = ch(0);
      @(posedge mclk);
      chk_reg("alternate", 8'h01, 8'((prev ^ ch(0)) === 14'h3FFF && (c == 7 || prev === GMTP_CHK_A || prev === GMTP_CHK_B)));
    end
    ce <= 1'b0;
    @(posedge mclk);
    prev = ch(0);
    repeat (3) @(posedge mclk);
    chk_sample("frozen", prev, ch(0));
    ce <= 1'b1;
    for (int c = 5; c <= 6; c++)
    begin
      wr(GMTP_ADDR_TEST, 8'(c) | (c == 5 ? 8'h20 : 8'h10));
      prev = ch(0);
      @(posedge mclk);
      chk_reg("pn held", 8'h01, 8'(prev === ch(0)));
      wr(GMTP_ADDR_TEST, 8'(c));
      prev = ch(0);
      @(posedge mclk);
      chk_reg("pn runs", 8'h01, 8'(prev !== ch(0)));
    end
    wr(GMTP_ADDR_TEST, 8'h09);
    chk_sample("reserved", 14'h1000, ch(0));
    $display("test patterns done");
    // The single-shot run is over before the write returns, so watch alongside it.
    for (int m = 0; m < 2; m++)
    begin
      wr(GMTP_ADDR_TEST, 8'h00);
      fork
        wr(GMTP_ADDR_TEST, m ? 8'h88 : 8'h08);
        begin
          for (int k = 0; k < 400 && ch(0) !== 14'h0111; k++)
            @(posedge mclk);
          for (int k = 0; k < 6; k++)
          begin
            chk_sample("user", (k < 4 || m == 0) ? user_pattern[(k % 4)*DW +: DW] : 14'h0000, ch(0));
            @(posedge mclk);
          end
        end
      join
    end
    $display("test user done");
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(GMTP_ADDR_MODES);
    chk_reg("modes reset", GMTP_MODES_RST, rv);
    rd(GMTP_ADDR_CLOCK);
    chk_reg("clock reset", GMTP_CLOCK_RST, rv);
    rd(GMTP_ADDR_TEST);
    chk_reg("test reset", GMTP_TEST_RST, rv);
    $display("test reset done");
    wrap_up();
  end
endmodule
